// [rtl/ter_pkg.sv]
// Purpose: constants for the translation event recorder
// Assumes: one 100 MHz clock, records of eight 32-bit words
// Notes: word 0 holds code, ssv and sub-context, word 1 the source
package ter_pkg;
    localparam int WORD_W = 32;
    localparam int SID_W = 32;
    localparam int SUB_W = 20;
    localparam int ADDR_W = 64;
    localparam int TSE_W = 6;
    localparam int SPL_W = 5;
    localparam logic [2:0] LAST_WORD = 3'h7;
    localparam logic [7:0] EV_UNSUPPORTED = 8'h01;
    localparam logic [7:0] EV_BAD_SOURCE = 8'h02;
    localparam logic [7:0] EV_STE_FETCH = 8'h03;
    localparam logic [7:0] EV_BAD_STE = 8'h04;
    localparam int W0_SSV = 11;
    localparam int W0_SUB_LSB = 12;
    localparam int W3_RNW = 0;
    localparam int W3_INSTR = 1;
    localparam int W3_PRIV = 2;
    localparam int W3_SECURE = 3;
    localparam int W3_STAGE = 4;
    localparam int W3_CLASS = 5;
    localparam int W3_STALL = 7;
    localparam logic [4:0] SPAN_RSV_MIN = 5'h0c;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MERGE_WINDOW_NS = 1000;
    localparam logic [7:0] MERGE_CYCLES = 8'(MERGE_WINDOW_NS / CLK_PERIOD_NS);
    localparam int FIFO_WIDTH = 34;
    localparam int FIFO_DEPTH = 32;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_EMIT = 3'b100
    } ter_state_e;
endpackage

// [rtl/ter_top.sv]
// Purpose: event record formatter with merge filter and record fifo
// Assumes: all inputs come from logic on clk_i
// Notes: a record drains only once all eight words sit in the fifo
`timescale 1ns/1ns
module ter_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } ter_fifo_s;
    ter_fifo_s f_ff;
    ter_fifo_s nxt_f;
    logic [WIDTH-1:0] mem [DEPTH];
    logic wr_en;
    logic rd_en;

    assign in_ready_o = f_ff.cnt != FULL_CNT;
    assign out_valid_o = f_ff.cnt != '0;
    assign out_data_o = mem[f_ff.rd];
    assign wr_en = in_valid_i && in_ready_o;
    assign rd_en = out_valid_o && out_ready_i;

    always_comb begin
        nxt_f = f_ff;
        if (wr_en) begin
            nxt_f.wr = f_ff.wr + AW'(1);
        end
        if (rd_en) begin
            nxt_f.rd = f_ff.rd + AW'(1);
        end
        nxt_f.cnt = f_ff.cnt + (AW+1)'(wr_en) - (AW+1)'(rd_en);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            f_ff <= '0;
        end else begin
            f_ff <= nxt_f;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            mem[f_ff.wr] <= in_data_i;
        end
    end
endmodule // ter_fifo

module ter_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [ter_pkg::SID_W-1:0] tx_source_id_i,
    input wire logic [ter_pkg::SUB_W-1:0] tx_sub_id_i,
    input wire logic tx_sub_valid_i,
    input wire logic tx_secure_i,
    input wire logic tx_read_i,
    input wire logic tx_instr_in_i,
    input wire logic tx_priv_in_i,
    input wire logic tx_instr_ovr_i,
    input wire logic tx_priv_ovr_i,
    input wire logic [ter_pkg::ADDR_W-1:0] tx_address_i,
    input wire logic tx_unsupported_i,
    input wire logic [ter_pkg::WORD_W-1:0] tx_reason_i,
    input wire logic tx_fault_i,
    input wire logic [7:0] tx_fault_code_i,
    input wire logic tx_stage_i,
    input wire logic [1:0] tx_class_i,
    input wire logic tx_stall_i,
    input wire logic [ter_pkg::ADDR_W-1:0] tx_fetch_addr_i,
    input wire logic tx_merge_enable_i,
    input wire logic [ter_pkg::SPL_W-1:0] first_level_span_i,
    input wire logic translation_enable_i,
    input wire logic [1:0] record_invalid_source_i,
    input wire logic [1:0][ter_pkg::TSE_W-1:0] table_size_exponent_i,
    input wire logic [1:0] table_format_i,
    input wire logic [1:0][ter_pkg::SPL_W-1:0] split_i,
    input wire logic [1:0] event_queue_enable_i,
    input wire logic [1:0] queue_full_i,
    input wire logic [1:0] queue_abort_i,
    output logic q_valid_o,
    input wire logic q_ready_i,
    output logic [ter_pkg::WORD_W-1:0] q_data_o,
    output logic q_last_o,
    output logic q_secure_o,
    output logic [15:0] merged_count_o,
    output logic [15:0] dropped_count_o
);
    import ter_pkg::*;

    typedef struct packed {
        ter_state_e state;
        logic [2:0] idx;
        logic [7:0][31:0] rec;
        logic rec_secure;
        logic last_valid;
        logic [7:0] timer;
        logic [15:0] merged;
        logic [15:0] dropped;
        logic [2:0] rec_cnt;
        logic out_valid;
        logic [31:0] out_data;
        logic out_last;
        logic out_secure;
    } ter_top_s;

    ter_top_s st_ff;
    ter_top_s nxt_st;
    logic [7:0][31:0] rec_new;
    logic [TSE_W-1:0] tse;
    logic [SPL_W-1:0] spl;
    logic [31:0] low_mask;
    logic [31:0] span_lim;
    logic oor_size;
    logic oor_two;
    logic bad_src;
    logic uut;
    logic flt;
    logic is_bsid;
    logic flt_rec;
    logic has_ev;
    logic [7:0] code;
    logic pre_lookup;
    logic stall;
    logic wr_ok;
    logic wait_ok;
    logic acc;
    logic same;
    logic merge_hit;
    logic acc_new;
    logic push;
    logic pop;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FIFO_WIDTH-1:0] fifo_in;
    logic [FIFO_WIDTH-1:0] fifo_out;

    // range checks on the source's own security state
    assign tse = table_size_exponent_i[tx_secure_i];
    assign spl = split_i[tx_secure_i];
    assign oor_size = (tx_source_id_i >> tse) != 32'h0;
    assign low_mask = (32'h1 << spl) - 32'h1;
    assign span_lim = 32'h1 << (first_level_span_i - 5'h1);
    assign oor_two = table_format_i[tx_secure_i] && (first_level_span_i == 5'h0
        || first_level_span_i >= SPAN_RSV_MIN
        || {1'b0, first_level_span_i} > {1'b0, spl} + 6'h1
        || (tx_source_id_i & low_mask) >= span_lim);
    assign bad_src = record_invalid_source_i[tx_secure_i] && translation_enable_i && (oor_size || oor_two);

    // unsupported upstream does not depend on translation enable
    assign uut = tx_unsupported_i;
    assign flt = tx_fault_i && translation_enable_i;
    assign is_bsid = !uut && bad_src;
    assign flt_rec = !uut && !bad_src && flt;
    assign has_ev = uut || bad_src || flt;
    assign code = uut ? EV_UNSUPPORTED : (bad_src ? EV_BAD_SOURCE : tx_fault_code_i);
    assign pre_lookup = code == EV_UNSUPPORTED || code == EV_BAD_SOURCE
        || code == EV_STE_FETCH || code == EV_BAD_STE;
    assign stall = flt_rec && tx_stall_i;
    assign wr_ok = event_queue_enable_i[tx_secure_i]
        && !queue_full_i[tx_secure_i] && !queue_abort_i[tx_secure_i];
    assign wait_ok = event_queue_enable_i[st_ff.rec_secure]
        && !queue_full_i[st_ff.rec_secure] && !queue_abort_i[st_ff.rec_secure];

    // record image built from the incoming transaction
    always_comb begin
        rec_new = '0;
        rec_new[0][7:0] = code;
        rec_new[0][W0_SSV] = tx_sub_valid_i;
        if (tx_sub_valid_i) begin
            rec_new[0][31:W0_SUB_LSB] = tx_sub_id_i;
        end
        rec_new[1] = tx_source_id_i;
        if (!is_bsid) begin
            rec_new[2] = tx_reason_i;
            rec_new[3][W3_RNW] = tx_read_i;
            rec_new[3][W3_INSTR] = uut ? tx_instr_in_i : tx_instr_ovr_i;
            rec_new[3][W3_PRIV] = uut ? tx_priv_in_i : tx_priv_ovr_i;
            rec_new[3][W3_SECURE] = tx_secure_i;
            rec_new[4] = tx_address_i[31:0];
            rec_new[5] = tx_address_i[63:32];
        end
        if (flt_rec) begin
            rec_new[3][W3_STAGE] = tx_stage_i;
            rec_new[3][W3_CLASS+:2] = tx_class_i;
            rec_new[3][W3_STALL] = tx_stall_i;
            rec_new[6] = tx_fetch_addr_i[31:0];
            rec_new[7] = tx_fetch_addr_i[63:32];
        end
    end

    // merge filter against the last written record
    assign acc = tx_valid_i && st_ff.state == ST_IDLE;
    assign same = st_ff.last_valid && st_ff.timer != 8'h0 && rec_new == st_ff.rec
        && tx_secure_i == st_ff.rec_secure;
    assign merge_hit = same && !stall && (pre_lookup || tx_merge_enable_i);
    assign acc_new = acc && has_ev && !merge_hit && (wr_ok || stall);

    assign push = st_ff.state == ST_EMIT && fifo_in_ready;
    assign fifo_in = {st_ff.rec_secure, st_ff.idx == LAST_WORD, st_ff.rec[st_ff.idx]};
    // drain only while a complete record is buffered
    assign pop = fifo_out_valid && st_ff.rec_cnt != 3'h0 && (!st_ff.out_valid || q_ready_i);

    always_comb begin
        nxt_st = st_ff;
        if (st_ff.timer != 8'h0) begin
            nxt_st.timer = st_ff.timer - 8'h1;
        end
        case (st_ff.state)
            ST_IDLE: begin
                if (acc && has_ev) begin
                    if (merge_hit) begin
                        nxt_st.merged = st_ff.merged + 16'h1;
                    end else if (!wr_ok && !stall) begin
                        nxt_st.dropped = st_ff.dropped + 16'h1;
                    end else begin
                        nxt_st.rec = rec_new;
                        nxt_st.rec_secure = tx_secure_i;
                        nxt_st.last_valid = 1'b0;
                        nxt_st.idx = 3'h0;
                        nxt_st.state = wr_ok ? ST_EMIT : ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (wait_ok) begin
                    nxt_st.state = ST_EMIT;
                end
            end
            ST_EMIT: begin
                if (fifo_in_ready) begin
                    nxt_st.idx = st_ff.idx + 3'h1;
                    if (st_ff.idx == LAST_WORD) begin
                        nxt_st.state = ST_IDLE;
                        nxt_st.last_valid = 1'b1;
                        nxt_st.timer = MERGE_CYCLES;
                    end
                end
            end
            default: begin
                nxt_st.state = ST_IDLE;
            end
        endcase
        if (pop) begin
            nxt_st.out_valid = 1'b1;
            nxt_st.out_data = fifo_out[31:0];
            nxt_st.out_last = fifo_out[32];
            nxt_st.out_secure = fifo_out[33];
        end else if (q_ready_i) begin
            nxt_st.out_valid = 1'b0;
        end
        case ({push && fifo_in[32], pop && fifo_out[32]})
            2'b10: nxt_st.rec_cnt = st_ff.rec_cnt + 3'h1;
            2'b01: nxt_st.rec_cnt = st_ff.rec_cnt - 3'h1;
            default: nxt_st.rec_cnt = st_ff.rec_cnt;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.state <= ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ter_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_out)
    );

    assign tx_ready_o = st_ff.state[0];
    assign q_valid_o = st_ff.out_valid;
    assign q_data_o = st_ff.out_data;
    assign q_last_o = st_ff.out_last;
    assign q_secure_o = st_ff.out_secure;
    assign merged_count_o = st_ff.merged;
    assign dropped_count_o = st_ff.dropped;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    rec_end_a: assert property (
        $fell(st_ff.state == ST_EMIT) |-> $past(push && fifo_in[32]))
        else $error("record ended without last word");
    queue_sel_a: assert property (
        acc_new |=> st_ff.rec_secure == $past(tx_secure_i))
        else $error("record steered to wrong queue");
    rnw_bit_a: assert property (
        acc_new && !is_bsid |=> st_ff.rec[3][W3_RNW] == $past(tx_read_i))
        else $error("read flag wrong");
    priv_ovr_a: assert property (
        acc_new && flt_rec |=> st_ff.rec[3][W3_PRIV] == $past(tx_priv_ovr_i))
        else $error("privilege not overridden value");
    uut_attr_a: assert property (
        acc_new && uut |=> st_ff.rec[0][7:0] == EV_UNSUPPORTED
            && st_ff.rec[3][W3_INSTR] == $past(tx_instr_in_i))
        else $error("unsupported record wrong");
    addr_keep_a: assert property (
        acc_new && !is_bsid |=> {st_ff.rec[5], st_ff.rec[4]} == $past(tx_address_i))
        else $error("address altered");
    bsid_zero_a: assert property (
        acc_new && is_bsid |=> st_ff.rec[7:2] == '0 && st_ff.rec[1] == $past(tx_source_id_i))
        else $error("bad source record not zero filled");
    stall_merge_a: assert property (
        acc && has_ev && stall |=> $stable(st_ff.merged) && st_ff.state != ST_IDLE)
        else $error("stalled event merged");
    mev_off_a: assert property (
        acc && has_ev && !pre_lookup && !tx_merge_enable_i && wr_ok |=> st_ff.state == ST_EMIT)
        else $error("event merged with merging disabled");
    drop_cnt_a: assert property (
        acc && has_ev && !merge_hit && !wr_ok && !stall
            |=> st_ff.dropped == $past(st_ff.dropped) + 16'h1 && st_ff.state == ST_IDLE)
        else $error("unwritable event not dropped");
    no_bsid_a: assert property (
        acc && !uut && !flt && !record_invalid_source_i[tx_secure_i] |=> st_ff.state == ST_IDLE)
        else $error("bad source recorded while disabled");
    visible_a: assert property (
        $rose(st_ff.out_valid) |-> $past(st_ff.rec_cnt) != 3'h0)
        else $error("partial record made visible");
    instr_ovr_a: assert property (
        acc_new && flt_rec |=> st_ff.rec[3][W3_INSTR] == $past(tx_instr_ovr_i))
        else $error("instruction flag not overridden value");
    uut_priv_a: assert property (
        acc_new && uut |=> st_ff.rec[3][W3_PRIV] == $past(tx_priv_in_i)
            && st_ff.rec[3][W3_SECURE] == $past(tx_secure_i))
        else $error("unsupported record attributes wrong");
    ssv_flag_a: assert property (
        acc_new |=> st_ff.rec[0][W0_SSV] == $past(tx_sub_valid_i))
        else $error("sub-context valid flag wrong");
    stage_bit_a: assert property (
        acc_new && flt_rec |=> st_ff.rec[3][W3_STAGE] == $past(tx_stage_i))
        else $error("fault stage wrong");
    class_bits_a: assert property (
        acc_new && flt_rec |=> st_ff.rec[3][W3_CLASS+:2] == $past(tx_class_i))
        else $error("fault class wrong");
    fetch_addr_a: assert property (
        acc_new && flt_rec |=> {st_ff.rec[7], st_ff.rec[6]} == $past(tx_fetch_addr_i))
        else $error("fetch address wrong");
    merge_cnt_a: assert property (
        acc && has_ev && merge_hit |=> st_ff.merged == $past(st_ff.merged) + 16'h1 && st_ff.state == ST_IDLE)
        else $error("merged event not counted");
    merge_window_a: assert property (
        acc && has_ev && st_ff.timer == 8'h0 |=> $stable(st_ff.merged))
        else $error("event merged outside window");
    bsid_code_a: assert property (
        acc_new && is_bsid |=> st_ff.rec[0][7:0] == EV_BAD_SOURCE)
        else $error("bad source code wrong");
endmodule // ter_top

// [verif/ter_sink.sv]
// Purpose: event queue consumer model for the record formatter
// Assumes: one word taken per handshake on clk_i
// Notes: hold_i withdraws ready to back up the record fifo
`timescale 1ns/1ns
module ter_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hold_i,
    input wire logic q_valid_i,
    input wire logic [ter_pkg::WORD_W-1:0] q_data_i,
    input wire logic q_last_i,
    input wire logic q_secure_i,
    output logic q_ready_o
);
    import ter_pkg::*;
    logic [33:0] got [0:255];
    int n;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_ready_o <= 1'h0;
            n <= 0;
        end else begin
            q_ready_o <= !hold_i;
            if (q_valid_i && q_ready_o) begin
                got[n[7:0]] <= {q_secure_i, q_last_i, q_data_i};
                n <= n + 1;
            end
        end
    end
endmodule // ter_sink

// [verif/testbench.sv]
// Purpose: self-checking bench for the event record formatter
// Assumes: sink model drains the record queue
// Notes: inputs move on the falling edge
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
    import ter_pkg::*;
    logic clk_i, rst_i, tx_valid_i, tx_ready_o, tx_sub_valid_i, tx_secure_i, tx_read_i, hold;
    logic tx_instr_in_i, tx_priv_in_i, tx_instr_ovr_i, tx_priv_ovr_i, tx_unsupported_i, tx_fault_i;
    logic tx_stage_i, tx_stall_i, tx_merge_enable_i, translation_enable_i, q_valid_o, q_ready_i;
    logic q_last_o, q_secure_o;
    logic [SID_W-1:0] tx_source_id_i;
    logic [SUB_W-1:0] tx_sub_id_i;
    logic [ADDR_W-1:0] tx_address_i, tx_fetch_addr_i;
    logic [WORD_W-1:0] tx_reason_i, q_data_o;
    logic [7:0] tx_fault_code_i;
    logic [1:0] tx_class_i, record_invalid_source_i, table_format_i, event_queue_enable_i;
    logic [1:0] queue_full_i, queue_abort_i;
    logic [SPL_W-1:0] first_level_span_i;
    logic [1:0][TSE_W-1:0] table_size_exponent_i;
    logic [1:0][SPL_W-1:0] split_i;
    logic [15:0] merged_count_o, dropped_count_o;
    logic [33:0] exp_q [$];
    int num_errors, num_checks, seen;

    ter_top dut_u (.clk_i, .rst_i, .tx_valid_i, .tx_ready_o, .tx_source_id_i, .tx_sub_id_i, .tx_sub_valid_i,
        .tx_secure_i, .tx_read_i, .tx_instr_in_i, .tx_priv_in_i, .tx_instr_ovr_i, .tx_priv_ovr_i,
        .tx_address_i, .tx_unsupported_i, .tx_reason_i, .tx_fault_i, .tx_fault_code_i, .tx_stage_i,
        .tx_class_i, .tx_stall_i, .tx_fetch_addr_i, .tx_merge_enable_i, .first_level_span_i,
        .translation_enable_i, .record_invalid_source_i, .table_size_exponent_i, .table_format_i,
        .split_i, .event_queue_enable_i, .queue_full_i, .queue_abort_i, .q_valid_o, .q_ready_i,
        .q_data_o, .q_last_o, .q_secure_o, .merged_count_o, .dropped_count_o);
    ter_sink sink_u (.clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .q_valid_i(q_valid_o),
        .q_data_i(q_data_o), .q_last_i(q_last_o), .q_secure_i(q_secure_o), .q_ready_o(q_ready_i));

    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic close_out();
        if (num_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic tmo();
        num_errors++;
        close_out();
    endtask

    task automatic clear();
        {tx_valid_i, tx_sub_valid_i, tx_secure_i, tx_read_i, tx_instr_in_i, tx_priv_in_i} = 6'h0;
        {tx_instr_ovr_i, tx_priv_ovr_i, tx_unsupported_i, tx_fault_i, tx_stage_i, tx_stall_i} = 6'h0;
        {tx_merge_enable_i, translation_enable_i, tx_class_i, record_invalid_source_i} = 6'h0;
        {table_format_i, queue_full_i, queue_abort_i, first_level_span_i} = 11'h0;
        event_queue_enable_i = 2'h3;
        tx_source_id_i = 32'h0000_0045;
        tx_sub_id_i = 20'h5a5a5;
        tx_address_i = 64'hff00_1234_8765_4320;
        tx_fetch_addr_i = 64'h0000_00ab_cdef_0040;
        tx_reason_i = 32'hc0de_0001;
        tx_fault_code_i = 8'h10;
        table_size_exponent_i = {6'h10, 6'h10};
        split_i = {5'h8, 5'h8};
    endtask

    // expected record from the presented fields: k 1 unsupported, 2 bad source, 0 fault
    task automatic rec(input int k);
        logic [31:0] w [8];
        logic [7:0] c;
        c = (k == 1) ? EV_UNSUPPORTED : (k == 2) ? EV_BAD_SOURCE : tx_fault_code_i;
        w = '{default: 32'h0};
        w[0] = {tx_sub_valid_i ? tx_sub_id_i : 20'h0, tx_sub_valid_i, 3'h0, c};
        w[1] = tx_source_id_i;
        if (k != 2) begin
            w[2] = tx_reason_i;
            w[3] = (k == 1) ? {28'h0, tx_secure_i, tx_priv_in_i, tx_instr_in_i, tx_read_i}
                : {24'h0, tx_stall_i, tx_class_i, tx_stage_i, tx_secure_i, tx_priv_ovr_i, tx_instr_ovr_i, tx_read_i};
            w[4] = tx_address_i[31:0];
            w[5] = tx_address_i[63:32];
            if (k == 0) begin
                w[6] = tx_fetch_addr_i[31:0];
                w[7] = tx_fetch_addr_i[63:32];
            end
        end
        for (int i = 0; i < 8; i++) exp_q.push_back({tx_secure_i, i == 7, w[i]});
    endtask

    task automatic fire();
        int t;
        for (t = 0; t < 400 && tx_ready_o !== 1'b1; t++) @(negedge clk_i);
        if (t == 400) tmo();
        tx_valid_i = 1'h1;
        @(negedge clk_i);
        tx_valid_i = 1'h0;
        @(negedge clk_i);
    endtask

    task automatic drain();
        int t;
        for (t = 0; t < 3000 && sink_u.n < exp_q.size(); t++) @(negedge clk_i);
        if (t == 3000) tmo();
        repeat (12) @(negedge clk_i);
        `CHK(sink_u.n, exp_q.size())
        for (int i = seen; i < exp_q.size(); i++) `CHK(sink_u.got[i], exp_q[i])
        seen = exp_q.size();
    endtask

    initial begin
        clear();
        hold = 1'h0;
        rst_i = 1'h1;
        repeat (16) @(negedge clk_i);
        rst_i = 1'h0;
        // unsupported upstream: translation off, secure, incoming attributes, merge disabled
        {tx_unsupported_i, tx_secure_i, tx_sub_valid_i, tx_instr_in_i, tx_read_i, tx_priv_ovr_i} = 6'h3f;
        fire();
        rec(1);
        drain();
        fire();
        `CHK(merged_count_o, 16'h1)
        drain();
        repeat (120) @(negedge clk_i);
        fire();
        rec(1);
        drain();
        // faults with overridden attributes, no sub-context
        clear();
        {translation_enable_i, tx_fault_i, tx_stage_i, tx_instr_ovr_i, tx_priv_in_i} = 5'h1f;
        tx_class_i = 2'h2;
        fire();
        rec(0);
        fire();
        rec(0);
        drain();
        tx_stage_i = 1'h0;
        for (int c = 0; c < 3; c++) begin
            tx_class_i = c[1:0];
            tx_fetch_addr_i[15:0] = 16'h0100 + 16'(c);
            fire();
            rec(0);
        end
        drain();
        tx_merge_enable_i = 1'h1;
        fire();
        `CHK(merged_count_o, 16'h2)
        tx_read_i = 1'h1;
        fire();
        rec(0);
        drain();
        tx_stall_i = 1'h1;
        fire();
        rec(0);
        fire();
        rec(0);
        drain();
        // unwritable queue: full, aborted, disabled
        tx_stall_i = 1'h0;
        for (int d = 0; d < 3; d++) begin
            tx_address_i[7:0] = 8'h80 + 8'(d);
            queue_full_i[0] = (d == 0);
            queue_abort_i[0] = (d == 1);
            event_queue_enable_i[0] = (d != 2);
            fire();
            `CHK(dropped_count_o, 16'(d + 1))
        end
        clear();
        {translation_enable_i, tx_fault_i, tx_stall_i} = 3'h7;
        queue_full_i = 2'h1;
        fire();
        repeat (20) @(negedge clk_i);
        `CHK(tx_ready_o, 1'b0)
        `CHK(sink_u.n, seen)
        queue_full_i = 2'h0;
        rec(0);
        drain();
        // out-of-range source, per-state sizes
        clear();
        translation_enable_i = 1'h1;
        record_invalid_source_i = 2'h3;
        table_size_exponent_i = {6'h08, 6'h04};
        tx_source_id_i = 32'h10;
        fire();
        rec(2);
        tx_secure_i = 1'h1;
        fire();
        tx_source_id_i = 32'h12c;
        fire();
        rec(2);
        {tx_secure_i, record_invalid_source_i} = 3'h2;
        tx_source_id_i = 32'h14;
        fire();
        drain();
        // two-level table span checks
        {record_invalid_source_i, table_format_i} = 4'hf;
        table_size_exponent_i = {6'h14, 6'h14};
        tx_source_id_i = 32'h3;
        fire();
        rec(2);
        first_level_span_i = 5'h3;
        split_i = {5'h4, 5'h1};
        tx_source_id_i = 32'h7;
        fire();
        rec(2);
        first_level_span_i = 5'h2;
        split_i = {5'h4, 5'h4};
        tx_source_id_i = 32'h5;
        fire();
        rec(2);
        first_level_span_i = 5'h3;
        tx_source_id_i = 32'h1;
        fire();
        drain();
        // record fifo filled while the consumer stalls
        clear();
        tx_unsupported_i = 1'h1;
        hold = 1'h1;
        for (int r = 0; r < 5; r++) begin
            tx_address_i[11:4] = 8'(r);
            fire();
            rec(1);
        end
        repeat (20) @(negedge clk_i);
        `CHK(tx_ready_o, 1'b0)
        `CHK(q_valid_o, 1'b1)
        hold = 1'h0;
        drain();
        close_out();
    end
endmodule // testbench
